/* File: design/aalu_core.sv */
// Accumulator add, add-with-carry and AND datapath with flag update.
//
// Contract
// RULE1: Writes to program counter low take two cycles.
// RULE2: Add with carry into accumulator, five flags.
// RULE3: Add with carry into memory, accumulator kept.
// RULE4: Add memory byte to accumulator, five flags.
// RULE5: Add immediate to accumulator, five flags.
// RULE6: Add into memory, accumulator kept, five flags.
// RULE7: AND memory into accumulator, zero flag only.
// RULE8: AND immediate into accumulator, zero flag only.
// RULE9: AND into memory, accumulator kept.
// RULE10: Zero flag follows whether result is zero.
// RULE11: Carries from bits 3, 7; signed wrap.
`timescale 1ns/1ps

module aalu_core
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Operation request
	input wire logic op_valid_in,
	input wire logic [2:0] op_code_in,
	input wire logic [7:0] mem_data_in,
	input wire logic [7:0] imm_data_in,
	input wire logic dest_is_program_counter_low_byte_in,
	output logic ready_out,
	output logic done_out,
	// Memory write-back
	output logic mem_wr_en_out,
	output logic [7:0] mem_wr_data_out,
	// Accumulator and flags
	output logic [7:0] acc_out,
	output logic zero_flag_out,
	output logic carry_flag_out,
	output logic nibble_carry_flag_out,
	output logic signed_wrap_flag_out,
	output logic aux_signed_flag_out
);

	// ------------------------------------------------------------
	// Operand selection and arithmetic
	// ------------------------------------------------------------
	aalu_pkg::aalu_op_t op;
	aalu_pkg::aalu_state_t state;
	aalu_pkg::aalu_state_t next_state;
	logic accept;
	logic to_mem;
	logic is_and;
	logic use_carry;
	logic [7:0] operand;
	logic [10:0] add_res;
	logic [7:0] result;
	logic [7:0] pend_data;
	logic [7:0] next_pend_data;
	logic next_ready;
	logic next_done;
	logic next_wr_en;
	logic [7:0] next_wr_data;
	logic [7:0] next_acc;
	logic next_zero;
	logic next_carry;
	logic next_nibble;
	logic next_wrap;
	logic next_aux;

	// Decode the operation into its operand source, destination and kind.
	always_comb
	begin
		op = aalu_pkg::aalu_op_t'(op_code_in);
		accept = op_valid_in && ready_out;
		to_mem = (op == aalu_pkg::OP_ADD_TO_MEM) || (op == aalu_pkg::OP_ADC_TO_MEM) ||
			(op == aalu_pkg::OP_AND_TO_MEM);
		is_and = (op == aalu_pkg::OP_AND_ACC) || (op == aalu_pkg::OP_AND_IMM) ||
			(op == aalu_pkg::OP_AND_TO_MEM);
		use_carry = (op == aalu_pkg::OP_ADC_ACC) || (op == aalu_pkg::OP_ADC_TO_MEM); // RULE2 RULE3
		operand = ((op == aalu_pkg::OP_ADD_IMM) || (op == aalu_pkg::OP_AND_IMM)) ?
			imm_data_in : mem_data_in; // RULE5 RULE8
		add_res = aalu_pkg::add_byte(acc_out, operand, use_carry && carry_flag_out); // RULE4
		result = is_and ? (acc_out & operand) : add_res[7:0]; // RULE7 RULE9
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Flags and accumulator settle on the accepting edge; a memory write aimed at the
	// program counter low byte is held one extra cycle so the fetch side sees two cycles.
	always_comb
	begin
		next_state = state;
		next_ready = ready_out;
		next_done = 1'b0;
		next_wr_en = 1'b0;
		next_wr_data = mem_wr_data_out;
		next_pend_data = pend_data;
		next_acc = acc_out;
		next_zero = zero_flag_out;
		next_carry = carry_flag_out;
		next_nibble = nibble_carry_flag_out;
		next_wrap = signed_wrap_flag_out;
		next_aux = aux_signed_flag_out;
		case (state)
			aalu_pkg::ST_READY:
			begin
				if (accept)
				begin
					next_zero = (result == aalu_pkg::ZERO_BYTE); // RULE10
					if (!is_and)
					begin
						next_carry = add_res[aalu_pkg::RES_CARRY_POS]; // RULE11
						next_nibble = add_res[aalu_pkg::RES_NIBBLE_POS]; // RULE11
						next_wrap = add_res[aalu_pkg::RES_WRAP_POS]; // RULE11
						next_aux = add_res[aalu_pkg::RES_WRAP_POS] ^ result[aalu_pkg::SIGN_BIT];
					end
					if (!to_mem)
					begin
						next_acc = result; // RULE2 RULE4 RULE5 RULE7 RULE8
						next_done = 1'b1;
					end
					else if (dest_is_program_counter_low_byte_in)
					begin
						next_pend_data = result; // RULE1
						next_ready = 1'b0;
						next_state = aalu_pkg::ST_SECOND;
					end
					else
					begin
						next_wr_en = 1'b1; // RULE3 RULE6 RULE9
						next_wr_data = result;
						next_done = 1'b1;
					end
				end
			end
			aalu_pkg::ST_SECOND:
			begin
				next_wr_en = 1'b1; // RULE1
				next_wr_data = pend_data;
				next_done = 1'b1;
				next_ready = 1'b1;
				next_state = aalu_pkg::ST_READY;
			end
			default:
			begin
				next_state = aalu_pkg::ST_READY;
				next_ready = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// All outputs come straight from these flops.
	always_ff @(posedge clk_sys_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state <= aalu_pkg::ST_READY;
			ready_out <= 1'b1;
			done_out <= 1'b0;
			mem_wr_en_out <= 1'b0;
			mem_wr_data_out <= aalu_pkg::ZERO_BYTE;
			pend_data <= aalu_pkg::ZERO_BYTE;
			acc_out <= aalu_pkg::ACC_RESET;
			zero_flag_out <= aalu_pkg::FLAG_RESET;
			carry_flag_out <= aalu_pkg::FLAG_RESET;
			nibble_carry_flag_out <= aalu_pkg::FLAG_RESET;
			signed_wrap_flag_out <= aalu_pkg::FLAG_RESET;
			aux_signed_flag_out <= aalu_pkg::FLAG_RESET;
		end
		else
		begin
			state <= next_state;
			ready_out <= next_ready;
			done_out <= next_done;
			mem_wr_en_out <= next_wr_en;
			mem_wr_data_out <= next_wr_data;
			pend_data <= next_pend_data;
			acc_out <= next_acc;
			zero_flag_out <= next_zero;
			carry_flag_out <= next_carry;
			nibble_carry_flag_out <= next_nibble;
			signed_wrap_flag_out <= next_wrap;
			aux_signed_flag_out <= next_aux;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);

	// Helper terms give the expected sums of this cycle's operands; the properties read them back with $past.
	logic [8:0] exp_sum_c;
	logic [8:0] exp_sum;
	always_comb
	begin
		exp_sum_c = {1'b0, acc_out} + {1'b0, mem_data_in} + {8'h00, carry_flag_out};
		exp_sum = {1'b0, acc_out} + {1'b0, operand};
	end

	sequence seq_pc_low_hold;
		!ready_out && !mem_wr_en_out && !done_out;
	endsequence
	sequence seq_pc_low_commit;
		ready_out && mem_wr_en_out && done_out;
	endsequence

	pc_low_two_a: assert property (accept && to_mem && dest_is_program_counter_low_byte_in // RULE1
		|=> seq_pc_low_hold ##1 seq_pc_low_commit) else $error("Low byte write not two cycles");
	// The held byte must be the one computed on the accepting edge, not a later operand.
	pc_low_data_a: assert property (accept && to_mem && // RULE1
		dest_is_program_counter_low_byte_in |=> ##1 mem_wr_data_out == $past(result, 2))
		else $error("Held write data wrong");
	adc_acc_a: assert property (accept && op == aalu_pkg::OP_ADC_ACC // RULE2
		|=> acc_out == $past(exp_sum_c[7:0]) && carry_flag_out == $past(exp_sum_c[8]))
		else $error("ADC into accumulator wrong");
	adc_mem_a: assert property (accept && op == aalu_pkg::OP_ADC_TO_MEM && // RULE3
		!dest_is_program_counter_low_byte_in |=> mem_wr_en_out &&
		mem_wr_data_out == $past(exp_sum_c[7:0]) && $stable(acc_out))
		else $error("ADC into memory wrong");
	add_acc_a: assert property (accept && op == aalu_pkg::OP_ADD_ACC // RULE4
		|=> acc_out == $past(acc_out) + $past(mem_data_in) && !mem_wr_en_out)
		else $error("ADD into accumulator wrong");
	add_imm_a: assert property (accept && op == aalu_pkg::OP_ADD_IMM // RULE5
		|=> acc_out == $past(acc_out) + $past(imm_data_in)) else $error("ADD immediate wrong");
	add_mem_a: assert property (accept && op == aalu_pkg::OP_ADD_TO_MEM && // RULE6
		!dest_is_program_counter_low_byte_in |=> mem_wr_en_out &&
		mem_wr_data_out == $past(exp_sum[7:0]) && $stable(acc_out))
		else $error("ADD into memory wrong");
	and_acc_a: assert property (accept && op == aalu_pkg::OP_AND_ACC // RULE7
		|=> acc_out == ($past(acc_out) & $past(mem_data_in)) && $stable(carry_flag_out) &&
		$stable(signed_wrap_flag_out)) else $error("AND into accumulator wrong");
	and_imm_a: assert property (accept && op == aalu_pkg::OP_AND_IMM // RULE8
		|=> acc_out == ($past(acc_out) & $past(imm_data_in)) && $stable(nibble_carry_flag_out))
		else $error("AND immediate wrong");
	and_mem_a: assert property (accept && op == aalu_pkg::OP_AND_TO_MEM && // RULE9
		!dest_is_program_counter_low_byte_in |=> mem_wr_en_out &&
		mem_wr_data_out == ($past(acc_out) & $past(mem_data_in)) && $stable(acc_out))
		else $error("AND into memory wrong");
	zero_acc_a: assert property (accept && !to_mem // RULE10
		|=> zero_flag_out == (acc_out == 8'h00)) else $error("Zero flag wrong");
	carry_bits_a: assert property (accept && op == aalu_pkg::OP_ADD_ACC // RULE11
		|=> carry_flag_out == $past(exp_sum[8]) &&
		nibble_carry_flag_out == $past({1'b0, acc_out[3:0]} + {1'b0, mem_data_in[3:0]} > 5'h0F))
		else $error("Carry flags wrong");

endmodule

/* File: design/aalu_pkg.sv */
// Package with the constants, types and adder function of the accumulator datapath.
package aalu_pkg;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic FLAG_RESET = 1'b0;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------
	// Adder field positions in the packed result of add_byte, and the nibble-top and sign bit positions of a byte
	// ------------------------------------------------------------
	localparam int RES_CARRY_POS = 10;
	localparam int RES_NIBBLE_POS = 9;
	localparam int RES_WRAP_POS = 8;
	localparam int NIBBLE_TOP_BIT = 3;
	localparam int SIGN_BIT = 7;

	// ------------------------------------------------------------
	// Operations and states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_ADD_ACC = 3'b000,
		OP_ADC_ACC = 3'b001,
		OP_ADD_IMM = 3'b010,
		OP_ADD_TO_MEM = 3'b011,
		OP_ADC_TO_MEM = 3'b100,
		OP_AND_ACC = 3'b101,
		OP_AND_IMM = 3'b110,
		OP_AND_TO_MEM = 3'b111
	} aalu_op_t;

	typedef enum logic [0:0] {
		ST_READY = 1'b0,
		ST_SECOND = 1'b1
	} aalu_state_t;

	// Eight-bit add with carry in; returns {carry, nibble carry, signed wrap, sum}.
	function automatic logic [10:0] add_byte(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] low;
		logic [8:0] full;
		logic wrap;
		low = {1'b0, a[NIBBLE_TOP_BIT:0]} + {1'b0, b[NIBBLE_TOP_BIT:0]} + {4'h0, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		wrap = (a[SIGN_BIT] == b[SIGN_BIT]) && (full[SIGN_BIT] != a[SIGN_BIT]);
		return {full[8], low[4], wrap, full[7:0]};
	endfunction

endpackage

/* File: bench/tb.sv */
// Self-checking testbench of the accumulator add and AND datapath.
`timescale 1ns/1ps

module tb;

	// ------------------------------------------------------------
	// Stimulus, model state and counters
	// ------------------------------------------------------------
	logic clk_sys_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic op_valid_in = 1'b0;
	logic [2:0] op_code_in = 3'h0;
	logic [7:0] mem_data_in = 8'h00;
	logic [7:0] imm_data_in = 8'h00;
	logic dest_is_program_counter_low_byte_in = 1'b0;
	logic ready_out, done_out, mem_wr_en_out;
	logic [7:0] mem_wr_data_out, acc_out;
	logic zero_flag_out, carry_flag_out, nibble_carry_flag_out;
	logic signed_wrap_flag_out, aux_signed_flag_out;
	logic [7:0] e_acc = 8'h00;
	logic e_z = 1'b0, e_c = 1'b0, e_nib = 1'b0, e_wrap = 1'b0, e_aux = 1'b0;
	int failures = 0;
	int checks = 0;
	int ntest = 0;

	aalu_core u_aalu_core (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.op_valid_in(op_valid_in), .op_code_in(op_code_in), .mem_data_in(mem_data_in),
		.imm_data_in(imm_data_in),
		.dest_is_program_counter_low_byte_in(dest_is_program_counter_low_byte_in),
		.ready_out(ready_out), .done_out(done_out), .mem_wr_en_out(mem_wr_en_out),
		.mem_wr_data_out(mem_wr_data_out), .acc_out(acc_out), .zero_flag_out(zero_flag_out),
		.carry_flag_out(carry_flag_out), .nibble_carry_flag_out(nibble_carry_flag_out),
		.signed_wrap_flag_out(signed_wrap_flag_out), .aux_signed_flag_out(aux_signed_flag_out));

	// Free-running 250 MHz clock.
	always #2 clk_sys_in = ~clk_sys_in;

	// Compares one byte and counts the outcome.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------
	// One operation: model update, request, completion and checks
	// ------------------------------------------------------------
	task automatic do_op(input logic [2:0] op, input logic [7:0] m, input logic [7:0] x,
		input logic pc);
		logic [7:0] b;
		logic [7:0] res;
		logic [8:0] s;
		logic [4:0] l;
		logic cin, is_and, to_mem, two;
		b = (op == aalu_pkg::OP_ADD_IMM || op == aalu_pkg::OP_AND_IMM) ? x : m;
		cin = (op == aalu_pkg::OP_ADC_ACC || op == aalu_pkg::OP_ADC_TO_MEM) & e_c;
		s = {1'b0, e_acc} + {1'b0, b} + {8'h00, cin};
		l = {1'b0, e_acc[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		is_and = (op == aalu_pkg::OP_AND_ACC || op == aalu_pkg::OP_AND_IMM
			|| op == aalu_pkg::OP_AND_TO_MEM);
		to_mem = (op == aalu_pkg::OP_ADD_TO_MEM || op == aalu_pkg::OP_ADC_TO_MEM
			|| op == aalu_pkg::OP_AND_TO_MEM);
		two = to_mem & pc;
		res = is_and ? (e_acc & b) : s[7:0];
		// Logic operations leave the four arithmetic flags as they were.
		if (!is_and)
		begin
			e_c = s[8];
			e_nib = l[4];
			e_wrap = (e_acc[7] == b[7]) && (s[7] != e_acc[7]);
			e_aux = e_wrap ^ s[7];
		end
		e_z = (res == 8'h00);
		if (!to_mem)
			e_acc = res;
		@(posedge clk_sys_in);
		op_valid_in <= 1'b1;
		op_code_in <= op;
		mem_data_in <= m;
		imm_data_in <= x;
		dest_is_program_counter_low_byte_in <= pc;
		@(posedge clk_sys_in);
		// A second request held in the busy cycle must be ignored.
		if (two)
			op_code_in <= aalu_pkg::OP_AND_IMM;
		else
			op_valid_in <= 1'b0;
		@(negedge clk_sys_in);
		chk({6'h00, done_out, ready_out}, {6'h00, !two, !two});
		if (two)
		begin
			chk({7'h00, mem_wr_en_out}, 8'h00);
			@(posedge clk_sys_in);
			op_valid_in <= 1'b0;
			@(negedge clk_sys_in);
			chk({6'h00, done_out, ready_out}, 8'h03);
		end
		chk({7'h00, mem_wr_en_out}, {7'h00, to_mem});
		if (to_mem)
			chk(mem_wr_data_out, res);
		chk(acc_out, e_acc);
		chk({7'h00, zero_flag_out}, {7'h00, e_z});
		chk({4'h0, carry_flag_out, nibble_carry_flag_out, signed_wrap_flag_out,
			aux_signed_flag_out}, {4'h0, e_c, e_nib, e_wrap, e_aux});
		ntest++;
		$display("test %0d done", ntest);
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk_sys_in);
		chk({7'h00, ready_out}, 8'h01);
		chk(acc_out, 8'h00);
		rst_n_in <= 1'b1;
		do_op(3'b000, 8'h7F, 8'h00, 1'b0);
		do_op(3'b010, 8'h55, 8'h01, 1'b0);
		do_op(3'b010, 8'h00, 8'h80, 1'b1);
		do_op(3'b001, 8'h0F, 8'h00, 1'b0);
		do_op(3'b011, 8'hF0, 8'h00, 1'b0);
		do_op(3'b100, 8'h05, 8'h00, 1'b1);
		do_op(3'b100, 8'hEF, 8'h00, 1'b0);
		do_op(3'b011, 8'h70, 8'h00, 1'b1);
		do_op(3'b101, 8'h30, 8'h00, 1'b0);
		do_op(3'b110, 8'h00, 8'h0F, 1'b0);
		do_op(3'b010, 8'h00, 8'hC3, 1'b0);
		do_op(3'b111, 8'h41, 8'h00, 1'b1);
		do_op(3'b111, 8'h3C, 8'h00, 1'b0);
		do_op(3'b101, 8'hFF, 8'h00, 1'b0);
		end_sim;
	end

	// Cuts a hang short well after the expected run of about 37 cycles.
	initial
	begin
		#4000;
		failures++;
		end_sim;
	end

endmodule
